// ===== piw_pkg.sv
package piw_pkg;
  // Source and vector counts
  localparam int unsigned NUM_SRC = 21;
  localparam int unsigned NUM_VEC = 10;
  localparam int unsigned VEC_IDX_W = 4;
  localparam int unsigned VADDR_W = 20;
  typedef logic [NUM_SRC-1:0] piw_src_t;
  typedef logic [NUM_VEC-1:0] piw_vec_t;
  typedef logic [VEC_IDX_W-1:0] piw_idx_t;

  // Priority levels, ordered so compare works
  typedef enum logic [1:0]
  {
    LVL_NONE = 2'h0,
    LVL_LOW = 2'h1,
    LVL_HIGH = 2'h2,
    LVL_TOP = 2'h3
  } piw_level_e;

  // Source bit positions
  localparam int unsigned SRC_CMP_TWO = 0;
  localparam int unsigned SRC_CMP_SEVEN = 1;
  localparam int unsigned SRC_CMP_THREE = 2;
  localparam int unsigned SRC_CMP_EIGHT = 3;
  localparam int unsigned SRC_EXT_B = 4;
  localparam int unsigned SRC_TMR0_LOW = 5;
  localparam int unsigned SRC_EXT_D = 6;
  localparam int unsigned SRC_EXT_C = 7;
  localparam int unsigned SRC_BASE = 8;
  localparam int unsigned SRC_TMR0_HIGH = 9;
  localparam int unsigned SRC_TMR1_LOW = 10;
  localparam int unsigned SRC_TMR1_HIGH = 11;
  localparam int unsigned SRC_URX = 12;
  localparam int unsigned SRC_SSP = 13;
  localparam int unsigned SRC_UTX = 14;
  localparam int unsigned SRC_ADC = 15;
  localparam int unsigned SRC_TMR_SIX = 16;
  localparam int unsigned SRC_TMR_SEVEN = 17;
  localparam int unsigned SRC_CMP_ONE_TO = 18;
  localparam int unsigned SRC_CMP_SIX = 19;
  localparam int unsigned SRC_SURGE = 20;

  // Vector addresses, index 0 is the smallest
  localparam logic [VADDR_W-1:0] VEC_ADDR [NUM_VEC] = '{
    20'h00003, 20'h0000b, 20'h00013, 20'h0001b, 20'h00023,
    20'h0002b, 20'h00033, 20'h0003b, 20'h00043, 20'h0004b
  };
  // Vectors that may use the top level instead of high
  localparam piw_vec_t VEC_TOP_CAPABLE = 10'h003;
  localparam piw_src_t SRC_HOLD_WAKE = 21'h000050;
  localparam piw_src_t SRC_ZERO = 21'h000000;
  localparam piw_vec_t VEC_ZERO = 10'h000;
  localparam logic [1:0] SEL_ZERO = 2'h0;
  // Nesting depth counter values
  localparam logic [2:0] STACK_EMPTY = 3'h0;
  localparam logic [2:0] STACK_ONE = 3'h1;
endpackage : piw_pkg

// ===== piw_grant_if.sv
`timescale 1ns/1ps
interface piw_grant_if;
  logic [piw_pkg::NUM_VEC-1:0] req;
  logic [piw_pkg::NUM_VEC-1:0] is_high;
  logic [1:0] cur_level;
  logic valid;
  logic [piw_pkg::VEC_IDX_W-1:0] idx;
  logic [1:0] level;
  modport ctl (output req, output is_high, output cur_level, input valid, input idx, input level);
  modport arb (input req, input is_high, input cur_level, output valid, output idx, output level);
endinterface : piw_grant_if

// ===== piw_arbiter.sv
`timescale 1ns/1ps
module piw_arbiter
(
  piw_grant_if.arb g
);
  logic [1:0] best_lvl;
  logic [piw_pkg::VEC_IDX_W-1:0] best_idx;
  logic [1:0] lvl;

  // Level of vector i as set by software
  function automatic logic [1:0] vec_level(input logic hi, input int unsigned i);
    logic [1:0] r;
    r = 2'(piw_pkg::LVL_LOW);
    if (hi)
      r = piw_pkg::VEC_TOP_CAPABLE[i] ? 2'(piw_pkg::LVL_TOP) : 2'(piw_pkg::LVL_HIGH);
    return r;
  endfunction : vec_level

  always_comb
  begin
    best_lvl = 2'(piw_pkg::LVL_NONE);
    best_idx = '0;
    lvl = '0;
    for (int unsigned i = 0; i < piw_pkg::NUM_VEC; i++)
    begin
      lvl = vec_level(g.is_high[i], i);
      if (g.req[i] && (lvl > best_lvl))
      begin
        best_lvl = lvl;
        best_idx = piw_pkg::VEC_IDX_W'(i);
      end
    end
  end

  assign g.valid = (best_lvl > g.cur_level);
  assign g.idx = best_idx;
  assign g.level = best_lvl;
endmodule : piw_arbiter

// ===== piw_ctrl.sv
// Function
// - Three nested levels; refuse requests not above the level in service.
// - Simultaneous requests: highest level granted first.
// - Equal level: smallest vector address wins.
// - Twenty-one sources merged onto ten vectors.
// - Vectors 03h and 0Bh carry comparator pairs, top or low level.
// - Vector 13h shares ext b, timer0 low, ext d; high or low.
// - 1Bh ext c/base timer, 23h timer0 high, 2Bh timer1; high or low.
// - 33h UART receive, 3Bh sync serial/UART transmit; high or low.
// - 43h shares ADC, timer six, timer seven, comparator one timeout.
// - 4Bh shares comparator six and surge detection; high or low.
// - Halt standby left on reset or any accepted request.
// - Full-stop standby wakes only on reset or ext b/d request.
`timescale 1ns/1ps
module piw_ctrl
(
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_ARST_N,
  input wire logic I_CLK_EN,
  // Source request levels, held by peripherals
  input wire logic [piw_pkg::NUM_SRC-1:0] I_SRC_REQ,
  input wire logic [piw_pkg::NUM_SRC-1:0] I_SRC_EN,
  // Per vector level select: 1 picks high or top, 0 low
  input wire logic [piw_pkg::NUM_VEC-1:0] I_VEC_HIGH,
  // Core handshake
  input wire logic I_GLOBAL_EN,
  input wire logic I_ACK,
  input wire logic I_RETI,
  input wire logic I_ENTER_HALT,
  input wire logic I_ENTER_HOLD,
  // Request to core
  output logic O_IRQ,
  output logic [piw_pkg::VADDR_W-1:0] O_VECTOR,
  output logic [1:0] O_LEVEL,
  output logic [1:0] O_CUR_LEVEL,
  // Standby state
  output logic O_HALTED,
  output logic O_HOLDING,
  output logic O_WAKE
);
  typedef enum logic [1:0]
  {
    ST_RUN = 2'h0,
    ST_HALT = 2'h1,
    ST_HOLD = 2'h2
  } piw_sb_e;

  piw_grant_if g();
  piw_sb_e sb_q;
  piw_sb_e sb_d;
  logic [piw_pkg::NUM_VEC-1:0] vec_req;
  logic [piw_pkg::NUM_SRC-1:0] act;
  logic [2:0] stack_q;
  logic [1:0] cur_q;
  logic [1:0] sav1_q;
  logic [1:0] sav2_q;
  logic irq_q;
  logic [piw_pkg::VADDR_W-1:0] vec_q;
  logic [1:0] lvl_q;
  logic wake_q;
  logic hold_wake;
  logic take;
  logic pop_ok;

  // Gathers grouped sources into one vector request
  function automatic logic any_of(input logic [piw_pkg::NUM_SRC-1:0] v,
                                  input logic [piw_pkg::NUM_SRC-1:0] m);
    return |(v & m);
  endfunction : any_of

  // Bit mask of one source
  function automatic logic [piw_pkg::NUM_SRC-1:0] sb(input int unsigned p);
    return piw_pkg::NUM_SRC'(1) << p;
  endfunction : sb

  assign act = I_SRC_REQ & I_SRC_EN;

  // Core took the pending request this cycle
  assign take = irq_q && I_ACK;
  // Return ignored on an empty stack
  assign pop_ok = I_RETI && (stack_q != piw_pkg::STACK_EMPTY);

  always_comb
  begin
    vec_req[0] = any_of(act, sb(piw_pkg::SRC_CMP_TWO) | sb(piw_pkg::SRC_CMP_SEVEN));
    vec_req[1] = any_of(act, sb(piw_pkg::SRC_CMP_THREE) | sb(piw_pkg::SRC_CMP_EIGHT));
    vec_req[2] = any_of(act, sb(piw_pkg::SRC_EXT_B) | sb(piw_pkg::SRC_TMR0_LOW)
                        | sb(piw_pkg::SRC_EXT_D));
    vec_req[3] = any_of(act, sb(piw_pkg::SRC_EXT_C) | sb(piw_pkg::SRC_BASE));
    vec_req[4] = any_of(act, sb(piw_pkg::SRC_TMR0_HIGH));
    vec_req[5] = any_of(act, sb(piw_pkg::SRC_TMR1_LOW) | sb(piw_pkg::SRC_TMR1_HIGH));
    vec_req[6] = any_of(act, sb(piw_pkg::SRC_URX));
    vec_req[7] = any_of(act, sb(piw_pkg::SRC_SSP) | sb(piw_pkg::SRC_UTX));
    vec_req[8] = any_of(act, sb(piw_pkg::SRC_ADC) | sb(piw_pkg::SRC_TMR_SIX)
                        | sb(piw_pkg::SRC_TMR_SEVEN) | sb(piw_pkg::SRC_CMP_ONE_TO));
    vec_req[9] = any_of(act, sb(piw_pkg::SRC_CMP_SIX) | sb(piw_pkg::SRC_SURGE));
  end

  assign g.req = vec_req;
  assign g.is_high = I_VEC_HIGH;
  assign g.cur_level = cur_q;

  piw_arbiter u_arb
  (
    .g(g)
  );

  // Registered request to core, retargets while unacknowledged
  always_ff @(posedge I_CLOCK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      irq_q <= 1'b0;
      vec_q <= '0;
      lvl_q <= piw_pkg::SEL_ZERO;
    end
    else if (I_CLK_EN)
    begin
      irq_q <= g.valid && I_GLOBAL_EN && !take;
      if (g.valid)
      begin
        vec_q <= piw_pkg::VEC_ADDR[g.idx];
        lvl_q <= g.level;
      end
    end
  end

  // Nesting stack of in-service levels
  always_ff @(posedge I_CLOCK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      stack_q <= piw_pkg::STACK_EMPTY;
      cur_q <= piw_pkg::SEL_ZERO;
      sav1_q <= piw_pkg::SEL_ZERO;
      sav2_q <= piw_pkg::SEL_ZERO;
    end
    else if (I_CLK_EN)
    begin
      if (take)
      begin
        sav2_q <= sav1_q;
        sav1_q <= cur_q;
        cur_q <= lvl_q;
        stack_q <= stack_q + piw_pkg::STACK_ONE;
      end
      else if (pop_ok)
      begin
        cur_q <= sav1_q;
        sav1_q <= sav2_q;
        sav2_q <= piw_pkg::SEL_ZERO;
        stack_q <= stack_q - piw_pkg::STACK_ONE;
      end
    end
  end

  // only ext b or d wake full stop
  assign hold_wake = any_of(act, piw_pkg::SRC_HOLD_WAKE);

  always_comb
  begin
    sb_d = sb_q;
    unique case (sb_q)
      ST_RUN:
      begin
        if (I_ENTER_HOLD)
          sb_d = ST_HOLD;
        else if (I_ENTER_HALT)
          sb_d = ST_HALT;
      end
      ST_HALT:
      begin
        if (g.valid)
          sb_d = ST_RUN;
      end
      ST_HOLD:
      begin
        if (hold_wake)
          sb_d = ST_RUN;
      end
      default:
        sb_d = ST_RUN;
    endcase
  end

  // reset pin or system reset releases standby
  always_ff @(posedge I_CLOCK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      sb_q <= ST_RUN;
      wake_q <= 1'b0;
    end
    else if (I_CLK_EN)
    begin
      sb_q <= sb_d;
      wake_q <= (sb_q != ST_RUN) && (sb_d == ST_RUN);
    end
  end

  assign O_IRQ = irq_q;
  assign O_VECTOR = vec_q;
  assign O_LEVEL = lvl_q;
  assign O_CUR_LEVEL = cur_q;
  assign O_HALTED = (sb_q == ST_HALT);
  assign O_HOLDING = (sb_q == ST_HOLD);
  assign O_WAKE = wake_q;
endmodule : piw_ctrl

// ===== piw_ctrl_props.sv
`timescale 1ns/1ps
module piw_ctrl_props
(
  // Clock, reset, inputs
  input wire logic I_CLOCK,
  input wire logic I_ARST_N,
  input wire logic I_CLK_EN,
  input wire logic [20:0] I_SRC_REQ,
  input wire logic [20:0] I_SRC_EN,
  input wire logic I_ACK,
  input wire logic I_RETI,
  input wire logic I_ENTER_HALT,
  input wire logic I_ENTER_HOLD,
  // Outputs
  input wire logic O_IRQ,
  input wire logic [19:0] O_VECTOR,
  input wire logic [1:0] O_LEVEL,
  input wire logic [1:0] O_CUR_LEVEL,
  input wire logic O_HALTED,
  input wire logic O_HOLDING,
  input wire logic O_WAKE
);
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_ARST_N);
  logic run;
  logic hold_src;
  assign run = !O_HALTED && !O_HOLDING;
  assign hold_src = (I_SRC_REQ & I_SRC_EN & piw_pkg::SRC_HOLD_WAKE) != 21'h0;
  sequence s_take;
    I_CLK_EN && O_IRQ && I_ACK;
  endsequence
  sequence s_hold_go;
    I_CLK_EN && O_HOLDING && hold_src;
  endsequence
  sequence s_woke;
    !O_HOLDING && O_WAKE;
  endsequence
  a_take_level: assert property (s_take |=> !O_IRQ && O_CUR_LEVEL == $past(O_LEVEL))
    else $error("level in service not taken from grant");
  a_above_cur: assert property (O_IRQ |-> O_LEVEL > O_CUR_LEVEL)
    else $error("request not above level in service");
  a_reti_pop: assert property (I_CLK_EN && I_RETI && !I_ACK && O_CUR_LEVEL != 2'h0
    |=> O_CUR_LEVEL < $past(O_CUR_LEVEL)) else $error("return did not pop level");
  a_vec_addr: assert property (O_IRQ |-> O_VECTOR[2:0] == 3'h3 && O_VECTOR <= 20'h0004b)
    else $error("vector address outside table");
  a_top_pair: assert property (O_IRQ && O_LEVEL == 2'h3 |-> O_VECTOR inside {20'h3, 20'hb})
    else $error("top level on wrong vector");
  a_hold_enter: assert property (I_CLK_EN && run && I_ENTER_HOLD |=> O_HOLDING)
    else $error("hold not entered");
  a_halt_enter: assert property (I_CLK_EN && run && I_ENTER_HALT && !I_ENTER_HOLD |=> O_HALTED)
    else $error("halt not entered");
  a_hold_stays: assert property (I_CLK_EN && O_HOLDING && !hold_src |=> O_HOLDING)
    else $error("hold left without wake source");
  a_hold_wake: assert property (s_hold_go |=> s_woke)
    else $error("hold not left on wake source");
  a_wake_once: assert property (I_CLK_EN && O_WAKE |=> !O_WAKE)
    else $error("wake pulse too long");
endmodule : piw_ctrl_props
bind piw_ctrl piw_ctrl_props piw_ctrl_props_inst (.*);

// ===== piw_core_model.sv
`timescale 1ns/1ps
module piw_core_model
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  // Request and answer
  input wire logic i_irq,
  input wire logic i_slow,
  output logic o_ack
);
  logic [1:0] wait_q;
  // One ack pulse per request, prompt or two cycles late
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_ack <= 1'b0;
      wait_q <= 2'h0;
    end
    else if (i_irq && !o_ack && (wait_q == 2'h2 || !i_slow))
    begin
      o_ack <= 1'b1;
      wait_q <= 2'h0;
    end
    else
    begin
      o_ack <= 1'b0;
      wait_q <= i_irq ? wait_q + 2'h1 : 2'h0;
    end
  end
endmodule : piw_core_model

// ===== test_priority_interrupt_wake.sv
`timescale 1ns/1ps
module test_priority_interrupt_wake;
  logic clk = 1'b0, rst_n = 1'b0, slow = 1'b0, gen = 1'b0, reti = 1'b0;
  logic halt = 1'b0, hold = 1'b0, ack, irq, halted, holding, wake;
  logic [20:0] req = 21'h0;
  logic [9:0] vhi = 10'h0;
  logic ce = 1'b1;
  logic [20:0] sen = 21'h1fffff;
  logic [19:0] vec;
  logic [1:0] lvl, cur;
  int err_count = 0;
  int num_checks = 0;
  always #12.5 clk = ~clk;
  piw_ctrl piw_ctrl_inst (.I_CLOCK(clk), .I_ARST_N(rst_n), .I_CLK_EN(ce), .I_SRC_REQ(req),
    .I_SRC_EN(sen), .I_VEC_HIGH(vhi), .I_GLOBAL_EN(gen), .I_ACK(ack), .I_RETI(reti),
    .I_ENTER_HALT(halt), .I_ENTER_HOLD(hold), .O_IRQ(irq), .O_VECTOR(vec), .O_LEVEL(lvl),
    .O_CUR_LEVEL(cur), .O_HALTED(halted), .O_HOLDING(holding), .O_WAKE(wake));
  piw_core_model piw_core_model_inst (.i_clock(clk), .i_arst_n(rst_n), .i_irq(irq),
    .i_slow(slow), .o_ack(ack));
  task chk(input string nm, input logic [19:0] e, input logic [19:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task wait_irq(input logic e);
    for (int i = 0; i < 20 && irq !== e; i++) step(1);
    chk("irq", {19'h0, e}, {19'h0, irq});
  endtask : wait_irq
  task pop;
    @(posedge clk) reti <= 1'b1;
    @(posedge clk) reti <= 1'b0;
    #1;
  endtask : pop
  task grant(input logic [19:0] v, input logic [19:0] l);
    wait_irq(1'b1);
    chk("vector", v, vec);
    chk("level", l, {18'h0, lvl});
    wait_irq(1'b0);
    chk("cur", l, {18'h0, cur});
  endtask : grant
  task s_map;
    int vi [21] = '{0, 0, 1, 1, 2, 2, 2, 3, 3, 4, 5, 5, 6, 7, 7, 8, 8, 8, 8, 9, 9};
    logic [19:0] el;
    for (int h = 0; h < 2; h++)
      for (int s = 0; s < 21; s++)
      begin
        el = (h == 0) ? 20'h1 : (vi[s] < 2) ? 20'h3 : 20'h2;
        @(posedge clk) vhi <= {10{h[0]}};
        req <= 21'h1 << s;
        grant(20'(vi[s] * 8 + 3), el);
        step(2);
        chk("refused", 20'h0, {19'h0, irq});
        @(posedge clk) req <= 21'h0;
        pop;
        chk("popped", 20'h0, {18'h0, cur});
      end
  endtask : s_map
  task s_prio;
    @(posedge clk) vhi <= 10'h202;
    slow <= 1'b1;
    req <= 21'h1fffff;
    grant(20'h0000b, 20'h3);
    step(3);
    chk("refused", 20'h0, {19'h0, irq});
    @(posedge clk) req <= 21'h1ffff3;
    pop;
    grant(20'h0004b, 20'h2);
    @(posedge clk) req <= 21'h07fff3;
    pop;
    grant(20'h00003, 20'h1);
    @(posedge clk) vhi <= 10'h008;
    grant(20'h0001b, 20'h2);
    @(posedge clk) req <= 21'h07fe70;
    pop;
    chk("nested", 20'h1, {18'h0, cur});
    @(posedge clk) req <= 21'h0;
    slow <= 1'b0;
    pop;
    chk("empty", 20'h0, {18'h0, cur});
  endtask : s_prio
  task s_standby;
    @(posedge clk) gen <= 1'b0;
    hold <= 1'b1;
    @(posedge clk) hold <= 1'b0;
    req <= 21'h000020;
    step(3);
    chk("holding", 20'h1, {19'h0, holding});
    @(posedge clk) req <= 21'h000060;
    sen <= 21'h1fffbf;
    step(2);
    chk("masked", 20'h1, {19'h0, holding});
    @(posedge clk) sen <= 21'h1fffff;
    step(1);
    chk("hold wake", 20'h1, {19'h0, wake & ~holding});
    @(posedge clk) req <= 21'h0;
    halt <= 1'b1;
    @(posedge clk) halt <= 1'b0;
    step(1);
    chk("halted", 20'h1, {19'h0, halted});
    @(posedge clk) req <= 21'h001000;
    step(1);
    chk("halt wake", 20'h1, {19'h0, wake & ~halted});
    chk("gated", 20'h0, {19'h0, irq});
    @(posedge clk) req <= 21'h0;
  endtask : s_standby
  task s_reset;
    @(posedge clk) ce <= 1'b0;
    hold <= 1'b1;
    @(posedge clk) hold <= 1'b0;
    ce <= 1'b1;
    step(1);
    chk("frozen", 20'h0, {19'h0, holding});
    @(posedge clk) hold <= 1'b1;
    @(posedge clk) hold <= 1'b0;
    step(1);
    chk("hold again", 20'h1, {19'h0, holding});
    @(posedge clk) rst_n <= 1'b0;
    step(1);
    chk("reset hold", 20'h0, {19'h0, holding});
    @(posedge clk) rst_n <= 1'b1;
    halt <= 1'b1;
    @(posedge clk) halt <= 1'b0;
    step(1);
    chk("halt again", 20'h1, {19'h0, halted});
    @(posedge clk) rst_n <= 1'b0;
    step(1);
    chk("reset halt", 20'h0, {19'h0, halted});
    @(posedge clk) rst_n <= 1'b1;
  endtask : s_reset
  task results;
    if (err_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk) gen <= 1'b1;
    s_map;
    s_prio;
    s_standby;
    s_reset;
    results;
  end
  initial
  begin
    #100us;
    err_count++;
    results;
  end
endmodule : test_priority_interrupt_wake
